// File: logic/rsm_map.vh
// Purpose: constants for the indication selector
// Assumes: 32-bit AXI4-Lite word registers
// Notes: included by rsm_indication_mux.v
`ifndef RSM_MAP_VH
`define RSM_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RSM_OFF_RX_CFG 5'h00
`define RSM_OFF_TX_CFG 5'h04
`define RSM_OFF_STATUS0 5'h08
`define RSM_OFF_STATUS1 5'h0c
`define RSM_OFF_FMT 5'h10
`define RSM_ADDR_W 5
`define RSM_IDX_SHIFT 2
// ----------------------------------------
// field positions
// ----------------------------------------
`define RSM_SEL_HI 7
`define RSM_SEL_LO 5
`define RSM_ST0_LINE_LOSS 0
`define RSM_ST0_SYS_LOSS 1
`define RSM_ST0_TX_LOSS 2
`define RSM_ST0_OVER_CUR 4
`define RSM_ST1_TXSYNC 4
`define RSM_ST1_RXSYNC 5
`define RSM_ST1_LINE_AIS 6
`define RSM_ST1_SYS_AIS 7
// ----------------------------------------
// format codes, 2 bits each; the reset value is 4 bits, covering both format fields
// ----------------------------------------
`define RSM_FMT_NRZ 2'h0
`define RSM_FMT_DUAL 2'h1
`define RSM_FMT_RST 4'h2
// ----------------------------------------
// select codes
// ----------------------------------------
`define RSM_SEL_PAT 3'h0
`define RSM_SEL_AIS 3'h1
`define RSM_SEL_S2 3'h2
`define RSM_SEL_S3 3'h3
`define RSM_SEL_EXZ 3'h4
`define RSM_SEL_BPV 3'h5
`define RSM_SEL_BOTH 3'h6
`define RSM_SEL_LOS 3'h7
`define RSM_SEL_RST 3'h0
// ----------------------------------------
// pattern detector figures
// ----------------------------------------
`define RSM_SYNC_BITS 7'h40
`define RSM_WIN_LAST 6'h3f
`define RSM_ERR_MAX 3'h6
// ----------------------------------------
// bus answers
// ----------------------------------------
`define RSM_RESP_OK 2'h0
`define RSM_RESP_ERR 2'h2
`endif

// File: logic/rsm_indication_mux.v
// Purpose: per-channel receive/transmit indication pin selector
// Assumes: one clock aclk; e1 ticks and events are synchronous strobes
// Notes: registers reached over AXI4-Lite
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rsm_map.vh"

// What this block does
// - receive single-rail NRZ: indication drives the negative-rail receive pin
// - receive dual-rail sliced: indication drives the recovered clock pin
// - receive source chosen by 3-bit field, bits 7 to 5, receive config
// - rx code 000: high while pattern synced, low one cycle per error
// - rx code 001: high while line alarm detected, as its status bit
// - rx code 010: XOR of positive and negative sliced receive data
// - rx code 011: recovered receive clock, same as its dedicated pin
// - rx codes 100/101: one-cycle pulse per excess zeroes / code violation
// - rx code 110: one-cycle pulse on excess zeroes or code violation
// - rx code 111: high while line loss of signal, as status bit
// - tx single-rail NRZ or dual-rail RZ: indication drives tx negative pin
// - transmit source chosen by 3-bit field, bits 7 to 5, transmit config
// - tx code 000: high while pattern synced, low one cycle per error
// - tx code 001: high while system alarm detected, as status bit
// - tx code 010: high while transmit over-current detected
// - tx code 011: high while transmit line loss of signal
// - tx codes 100/101/110: pulse on excess zeroes, violation, or either
// - tx code 111: high while system-side loss of signal
// - tx single-rail NRZ disables violation, combined and system loss codes
// - sync after over 64 matching bits; lose it on over 6 errors per 64
module rsm_indication_mux (
  input wire aclk,
  input wire aresetn,
  input wire aclken,
  input wire [`RSM_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`RSM_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_e1_tick,
  input wire rx_recovered_clock,
  input wire rx_positive_rail_data,
  input wire rx_negative_rail_data,
  input wire rx_pattern_mismatch,
  input wire line_alarm_signal,
  input wire line_excess_zeroes,
  input wire line_code_violation,
  input wire line_signal_loss,
  input wire tx_e1_tick,
  input wire tx_pattern_mismatch,
  input wire system_alarm_signal,
  input wire tx_over_current,
  input wire tx_line_signal_loss,
  input wire system_excess_zeroes,
  input wire system_code_violation,
  input wire system_signal_loss,
  output reg rx_negative_rail_pin,
  output reg rx_recovered_clock_pin,
  input wire tx_negative_rail_pin_in,
  output wire tx_negative_rail_pin_out,
  output wire tx_negative_rail_pin_oe,
  output wire tx_negative_rail_data,
  output reg rx_indication_out,
  output reg tx_indication_out
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg [2:0] rx_indication_select_reg;
  reg [2:0] tx_indication_select_reg;
  reg [3:0] fmt_reg;
  reg [`RSM_ADDR_W-1:0] awaddr_reg;
  reg aw_held_reg;
  reg [7:0] wdata_reg;
  reg wstrb0_reg;
  reg w_held_reg;
  wire [1:0] rx_fmt;
  wire [1:0] tx_fmt;
  wire [1:0] pd_sync;
  wire [1:0] pd_tick;
  wire [1:0] pd_err;

  assign rx_fmt = fmt_reg[1:0];
  assign tx_fmt = fmt_reg[3:2];

  // ----------------------------------------
  // pattern synchronisation, one per direction
  // ----------------------------------------
  assign pd_tick = {tx_e1_tick, rx_e1_tick};
  assign pd_err = {tx_pattern_mismatch, rx_pattern_mismatch};

  genvar d;
  generate
    for (d = 0; d < 2; d = d + 1) begin : g_pd
      reg sync_reg;
      reg [6:0] match_reg;
      reg [5:0] win_reg;
      reg [2:0] errs_reg;
      assign pd_sync[d] = sync_reg;
      always @(posedge aclk) begin
        if (!aresetn) begin
          sync_reg <= 1'b0;
          match_reg <= 7'h00;
          win_reg <= 6'h00;
          errs_reg <= 3'h0;
        end else if (aclken && pd_tick[d]) begin
          if (!sync_reg) begin
            win_reg <= 6'h00;
            errs_reg <= 3'h0;
            if (pd_err[d]) begin
              match_reg <= 7'h00;
            end else if (match_reg == `RSM_SYNC_BITS) begin
              sync_reg <= 1'b1;
              match_reg <= 7'h00;
            end else begin
              match_reg <= match_reg + 7'h01;
            end
          end else if (pd_err[d] && errs_reg == `RSM_ERR_MAX) begin
            sync_reg <= 1'b0;
            win_reg <= 6'h00;
            errs_reg <= 3'h0;
          end else if (win_reg == `RSM_WIN_LAST) begin
            win_reg <= 6'h00;
            errs_reg <= 3'h0;
          end else begin
            win_reg <= win_reg + 6'h01;
            if (pd_err[d]) begin
              errs_reg <= errs_reg + 3'h1;
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // receive source selection
  // ----------------------------------------
  reg rx_ind_next;
  always @* begin
    rx_ind_next = 1'b0;
    case (rx_indication_select_reg)
      `RSM_SEL_PAT: rx_ind_next = pd_sync[0] & ~rx_pattern_mismatch;
      `RSM_SEL_AIS: rx_ind_next = line_alarm_signal;
      `RSM_SEL_S2: rx_ind_next = rx_positive_rail_data ^ rx_negative_rail_data;
      `RSM_SEL_S3: rx_ind_next = rx_recovered_clock;
      `RSM_SEL_EXZ: rx_ind_next = line_excess_zeroes;
      `RSM_SEL_BPV: rx_ind_next = line_code_violation;
      `RSM_SEL_BOTH: rx_ind_next = line_excess_zeroes | line_code_violation;
      `RSM_SEL_LOS: rx_ind_next = line_signal_loss;
      default: rx_ind_next = 1'b0;
    endcase
  end

  // ----------------------------------------
  // transmit source selection
  // ----------------------------------------
  reg tx_ind_next;
  wire tx_nrz;
  assign tx_nrz = (tx_fmt == `RSM_FMT_NRZ);
  always @* begin
    tx_ind_next = 1'b0;
    case (tx_indication_select_reg)
      `RSM_SEL_PAT: tx_ind_next = pd_sync[1] & ~tx_pattern_mismatch;
      `RSM_SEL_AIS: tx_ind_next = system_alarm_signal;
      `RSM_SEL_S2: tx_ind_next = tx_over_current;
      `RSM_SEL_S3: tx_ind_next = tx_line_signal_loss;
      `RSM_SEL_EXZ: tx_ind_next = system_excess_zeroes;
      `RSM_SEL_BPV: tx_ind_next = ~tx_nrz & system_code_violation;
      `RSM_SEL_BOTH: tx_ind_next = ~tx_nrz & (system_excess_zeroes | system_code_violation);
      `RSM_SEL_LOS: tx_ind_next = ~tx_nrz & system_signal_loss;
      default: tx_ind_next = 1'b0;
    endcase
  end

  // ----------------------------------------
  // indication registers
  // ----------------------------------------
  wire rx_is_clock;
  assign rx_is_clock = (rx_indication_select_reg == `RSM_SEL_S3);
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_indication_out <= 1'b0;
      tx_indication_out <= 1'b0;
    end else if (aclken) begin
      if (rx_e1_tick || rx_is_clock) begin
        rx_indication_out <= rx_ind_next;
      end
      if (tx_e1_tick) begin
        tx_indication_out <= tx_ind_next;
      end
    end
  end

  // ----------------------------------------
  // pin multiplexing
  // ----------------------------------------
  wire rx_nrz;
  wire rx_dual;
  assign rx_nrz = (rx_fmt == `RSM_FMT_NRZ);
  assign rx_dual = (rx_fmt == `RSM_FMT_DUAL);
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_negative_rail_pin <= 1'b0;
      rx_recovered_clock_pin <= 1'b0;
    end else if (aclken) begin
      if (rx_nrz) begin
        rx_negative_rail_pin <= rx_ind_next;
      end else begin
        rx_negative_rail_pin <= rx_negative_rail_data;
      end
      if (rx_dual) begin
        rx_recovered_clock_pin <= rx_ind_next;
      end else begin
        rx_recovered_clock_pin <= rx_recovered_clock;
      end
    end
  end

  wire tx_dual;
  assign tx_dual = (tx_fmt == `RSM_FMT_DUAL);
  assign tx_negative_rail_pin_oe = tx_nrz | tx_dual;
  assign tx_negative_rail_pin_out = tx_indication_out;
  assign tx_negative_rail_data = tx_negative_rail_pin_oe ? 1'b0 : tx_negative_rail_pin_in;

  // ----------------------------------------
  // word index of each bus request
  // ----------------------------------------
  wire [`RSM_ADDR_W-1:0] wr_index;
  wire [`RSM_ADDR_W-1:0] rd_index;
  assign wr_index = awaddr_reg >> `RSM_IDX_SHIFT;
  assign rd_index = s_axi_araddr >> `RSM_IDX_SHIFT;

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  wire do_write;
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= {`RSM_ADDR_W{1'b0}};
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RSM_RESP_OK;
      rx_indication_select_reg <= `RSM_SEL_RST;
      tx_indication_select_reg <= `RSM_SEL_RST;
      fmt_reg <= `RSM_FMT_RST;
    end else if (aclken) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RSM_RESP_OK;
        case (wr_index)
          (`RSM_OFF_RX_CFG >> `RSM_IDX_SHIFT): begin
            if (wstrb0_reg) begin
              rx_indication_select_reg <= wdata_reg[`RSM_SEL_HI:`RSM_SEL_LO];
            end
          end
          (`RSM_OFF_TX_CFG >> `RSM_IDX_SHIFT): begin
            if (wstrb0_reg) begin
              tx_indication_select_reg <= wdata_reg[`RSM_SEL_HI:`RSM_SEL_LO];
            end
          end
          (`RSM_OFF_STATUS0 >> `RSM_IDX_SHIFT): s_axi_bresp <= `RSM_RESP_OK;
          (`RSM_OFF_STATUS1 >> `RSM_IDX_SHIFT): s_axi_bresp <= `RSM_RESP_OK;
          (`RSM_OFF_FMT >> `RSM_IDX_SHIFT): begin
            if (wstrb0_reg) begin
              fmt_reg <= wdata_reg[3:0];
            end
          end
          default: s_axi_bresp <= `RSM_RESP_ERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  reg [7:0] status0_val;
  reg [7:0] status1_val;
  always @* begin
    status0_val = 8'h00;
    status1_val = 8'h00;
    status0_val[`RSM_ST0_LINE_LOSS] = line_signal_loss;
    status0_val[`RSM_ST0_SYS_LOSS] = system_signal_loss;
    status0_val[`RSM_ST0_TX_LOSS] = tx_line_signal_loss;
    status0_val[`RSM_ST0_OVER_CUR] = tx_over_current;
    status1_val[`RSM_ST1_TXSYNC] = pd_sync[1];
    status1_val[`RSM_ST1_RXSYNC] = pd_sync[0];
    status1_val[`RSM_ST1_LINE_AIS] = line_alarm_signal;
    status1_val[`RSM_ST1_SYS_AIS] = system_alarm_signal;
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RSM_RESP_OK;
    end else if (aclken) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RSM_RESP_OK;
        s_axi_rdata <= 32'h0000_0000;
        case (rd_index)
          (`RSM_OFF_RX_CFG >> `RSM_IDX_SHIFT): s_axi_rdata[`RSM_SEL_HI:`RSM_SEL_LO] <= rx_indication_select_reg;
          (`RSM_OFF_TX_CFG >> `RSM_IDX_SHIFT): s_axi_rdata[`RSM_SEL_HI:`RSM_SEL_LO] <= tx_indication_select_reg;
          (`RSM_OFF_STATUS0 >> `RSM_IDX_SHIFT): s_axi_rdata[7:0] <= status0_val;
          (`RSM_OFF_STATUS1 >> `RSM_IDX_SHIFT): s_axi_rdata[7:0] <= status1_val;
          (`RSM_OFF_FMT >> `RSM_IDX_SHIFT): s_axi_rdata[3:0] <= fmt_reg;
          default: s_axi_rresp <= `RSM_RESP_ERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// File: bench/rsm_sva.sv
// Purpose: port assertions for the indication selector
// Assumes: bench offers write address and data together
// Notes: select and format fields shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "rsm_map.vh"
module rsm_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  input wire logic [`RSM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic rx_e1_tick,
  input wire logic rx_positive_rail_data,
  input wire logic rx_negative_rail_data,
  input wire logic line_excess_zeroes,
  input wire logic line_code_violation,
  input wire logic line_signal_loss,
  input wire logic tx_e1_tick,
  input wire logic tx_over_current,
  input wire logic rx_negative_rail_pin,
  input wire logic tx_negative_rail_pin_oe,
  input wire logic rx_indication_out,
  input wire logic tx_indication_out
);
  // ---
  // shadow fields
  // ---
  logic pend_reg, fk_reg;
  logic [4:0] pa_reg;
  logic [7:0] pd_reg;
  logic [2:0] rs_reg, ts_reg;
  logic [3:0] fm_reg;
  always_ff @(posedge aclk) begin
    pa_reg <= s_axi_awaddr;
    pd_reg <= s_axi_wdata[7:0];
    pend_reg <= aresetn && aclken && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    if (!aresetn) begin
      rs_reg <= `RSM_SEL_RST;
      ts_reg <= `RSM_SEL_RST;
      fm_reg <= `RSM_FMT_RST;
      fk_reg <= 1'b0;
    end else if (pend_reg) begin
      if (pa_reg == 5'h00) rs_reg <= pd_reg[7:5];
      if (pa_reg == 5'h04) ts_reg <= pd_reg[7:5];
      if (pa_reg == 5'h10) fm_reg <= pd_reg[3:0];
      if (pa_reg == 5'h10) fk_reg <= 1'b1;
    end
  end
  // ---
  // properties
  // ---
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rt; rx_e1_tick && aclken; endsequence
  sequence s_tt; tx_e1_tick && aclken; endsequence
  property p_rx_bpv; s_rt ##0 (rs_reg == `RSM_SEL_BPV) |=> rx_indication_out == $past(line_code_violation); endproperty
  a_rx_bpv: assert property (p_rx_bpv) else $error("rx violation pulse wrong");
  property p_rx_both; s_rt ##0 (rs_reg == `RSM_SEL_BOTH) |=> rx_indication_out == $past(line_excess_zeroes | line_code_violation); endproperty
  a_rx_both: assert property (p_rx_both) else $error("rx combined pulse wrong");
  property p_rx_los; s_rt ##0 (rs_reg == `RSM_SEL_LOS) |=> rx_indication_out == $past(line_signal_loss); endproperty
  a_rx_los: assert property (p_rx_los) else $error("rx loss level wrong");
  property p_rx_xor; s_rt ##0 (rs_reg == `RSM_SEL_S2) |=> rx_indication_out == $past(rx_positive_rail_data ^ rx_negative_rail_data); endproperty
  a_rx_xor: assert property (p_rx_xor) else $error("rx rail xor wrong");
  property p_rx_nrz; s_rt ##0 (fm_reg[1:0] == `RSM_FMT_NRZ) |=> rx_negative_rail_pin == rx_indication_out; endproperty
  a_rx_nrz: assert property (p_rx_nrz) else $error("rx pin not indication");
  property p_tx_oe; fk_reg |-> tx_negative_rail_pin_oe == (fm_reg[3:2] == `RSM_FMT_NRZ || fm_reg[3:2] == `RSM_FMT_DUAL); endproperty
  a_tx_oe: assert property (p_tx_oe) else $error("tx pin enable wrong");
  property p_tx_res; s_tt ##0 (fk_reg && fm_reg[3:2] == `RSM_FMT_NRZ && ts_reg >= `RSM_SEL_BPV) |=> !tx_indication_out; endproperty
  a_tx_res: assert property (p_tx_res) else $error("tx disabled code active");
  property p_tx_oc; s_tt ##0 (ts_reg == `RSM_SEL_S2) |=> tx_indication_out == $past(tx_over_current); endproperty
  a_tx_oc: assert property (p_tx_oc) else $error("tx over-current wrong");
endmodule
bind rsm_indication_mux rsm_sva u_rsm_sva (.*);
`default_nettype wire

// File: bench/rsm_framer_model.sv
// Purpose: system-side framer driving the shared tx pin
// Assumes: pin has no pull, so undriven data keeps toggling
// Notes: wire level resolved from the selector's output enable alone
`timescale 1ns/1ps
`default_nettype none
module rsm_framer_model (
  input wire logic aclk,
  input wire logic pin_oe,
  input wire logic pin_out,
  output logic pin_level
);
  logic drv_reg = 1'b0;
  always @(posedge aclk) drv_reg <= ~drv_reg;
  assign pin_level = pin_oe ? pin_out : drv_reg;
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: self-checking bench for the indication selector
// Assumes: e1 ticks every second clock, bus answers awaited
// Notes: tx pin level comes from the framer model
`timescale 1ns/1ps
`default_nettype none
`include "rsm_map.vh"
module tb_top;
  logic aclk, aresetn, aclken, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, e;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [`RSM_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rx_e1_tick, rx_recovered_clock, rx_positive_rail_data, rx_negative_rail_data;
  logic rx_pattern_mismatch, line_alarm_signal, line_excess_zeroes, line_code_violation;
  logic line_signal_loss, tx_e1_tick, tx_pattern_mismatch, system_alarm_signal, tx_over_current;
  logic tx_line_signal_loss, system_excess_zeroes, system_code_violation, system_signal_loss;
  logic rx_negative_rail_pin, rx_recovered_clock_pin, tx_negative_rail_pin_in;
  logic tx_negative_rail_pin_out, tx_negative_rail_pin_oe, tx_negative_rail_data;
  logic rx_indication_out, tx_indication_out;
  logic [2:0] lc [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  rsm_indication_mux u_rsm_indication_mux (.*);
  rsm_framer_model u_rsm_framer_model (.aclk(aclk), .pin_oe(tx_negative_rail_pin_oe),
    .pin_out(tx_negative_rail_pin_out), .pin_level(tx_negative_rail_pin_in));
  // ---
  // tasks
  // ---
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic cb(input logic g, input logic x);
    chk({31'h0, g}, {31'h0, x});
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] x, input logic [1:0] r);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, x);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic sel(input logic [2:0] k);
    wr(`RSM_OFF_RX_CFG, {24'h0, k, 5'h0}, 4'hf, `RSM_RESP_OK);
    wr(`RSM_OFF_TX_CFG, {24'h0, k, 5'h0}, 4'hf, `RSM_RESP_OK);
  endtask
  task automatic tk(input logic x, input logic c, input logic m);
    {rx_e1_tick, tx_e1_tick, rx_pattern_mismatch, tx_pattern_mismatch} <= {2'h3, m, m};
    {line_excess_zeroes, system_excess_zeroes, line_code_violation, system_code_violation} <= {x, x, c, c};
    @(posedge aclk);
    {rx_e1_tick, tx_e1_tick, rx_pattern_mismatch, tx_pattern_mismatch} <= 4'h0;
    {line_excess_zeroes, system_excess_zeroes, line_code_violation, system_code_violation} <= 4'h0;
    @(posedge aclk);
  endtask
  task automatic lv(input logic v);
    {line_alarm_signal, line_signal_loss, rx_recovered_clock, system_alarm_signal} <= {4{v}};
    {tx_over_current, tx_line_signal_loss, system_signal_loss} <= {3{v}};
    {rx_positive_rail_data, rx_negative_rail_data} <= {1'b1, ~v};
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ---
  // clock, watchdog, tests
  // ---
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    {aclk, aresetn, aclken} = 3'h1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, rx_e1_tick, tx_e1_tick} = '0;
    {line_excess_zeroes, system_excess_zeroes, line_code_violation, system_code_violation} = '0;
    {rx_pattern_mismatch, tx_pattern_mismatch} = '0;
    lv(1'b0);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`RSM_OFF_RX_CFG, 32'h0, `RSM_RESP_OK);
    rd(5'h14, 32'h0, `RSM_RESP_ERR);
    wr(5'h14, 32'h0, 4'hf, `RSM_RESP_ERR);
    wr(`RSM_OFF_FMT, 32'h4, 4'hf, `RSM_RESP_OK);
    $display("test registers done");
    for (logic [3:0] k = 4; k < 7; k++) begin
      sel(k[2:0]);
      for (logic [2:0] i = 0; i < 4; i++) begin
        tk(i[0], i[1], 1'b0);
        e = (k == 4) ? i[0] : (k == 5) ? i[1] : (i[0] | i[1]);
        cb(rx_indication_out, e);
        cb(tx_indication_out, e);
        cb(tx_negative_rail_pin_out, e);
      end
    end
    $display("test pulses done");
    wr(`RSM_OFF_FMT, 32'h0, 4'hf, `RSM_RESP_OK);
    lv(1'b1);
    for (logic [3:0] k = 4; k < 8; k++) begin
      wr(`RSM_OFF_TX_CFG, {24'h0, k[2:0], 5'h0}, 4'hf, `RSM_RESP_OK);
      tk(1'b1, 1'b1, 1'b0);
      cb(tx_indication_out, k == 4);
    end
    $display("test nrz done");
    wr(`RSM_OFF_FMT, 32'ha, 4'hf, `RSM_RESP_OK);
    for (int j = 0; j < 4; j++) begin
      sel(lc[j]);
      for (logic [1:0] v = 0; v < 2; v++) begin
        lv(v[0]);
        tk(1'b0, 1'b0, 1'b0);
        cb(rx_indication_out, v[0]);
        cb(tx_indication_out, v[0]);
      end
    end
    cb(tx_negative_rail_pin_oe, 1'b0);
    cb(tx_negative_rail_data, tx_negative_rail_pin_in);
    rd(`RSM_OFF_STATUS0, 32'h17, `RSM_RESP_OK);
    rd(`RSM_OFF_STATUS1, 32'hc0, `RSM_RESP_OK);
    wr(`RSM_OFF_STATUS0, 32'h0, 4'hf, `RSM_RESP_OK);
    rd(`RSM_OFF_STATUS0, 32'h17, `RSM_RESP_OK);
    wr(`RSM_OFF_RX_CFG, 32'h20, 4'h0, `RSM_RESP_OK);
    rd(`RSM_OFF_RX_CFG, 32'he0, `RSM_RESP_OK);
    wr(`RSM_OFF_FMT, 32'h1, 4'hf, `RSM_RESP_OK);
    rx_recovered_clock <= 1'b0;
    tk(1'b0, 1'b0, 1'b0);
    cb(rx_recovered_clock_pin, 1'b1);
    cb(rx_negative_rail_pin, 1'b0);
    cb(tx_negative_rail_pin_oe, 1'b1);
    cb(tx_negative_rail_data, 1'b0);
    aclken <= 1'b0;
    lv(1'b0);
    tk(1'b0, 1'b0, 1'b0);
    cb(rx_indication_out, 1'b1);
    aclken <= 1'b1;
    tk(1'b0, 1'b0, 1'b0);
    cb(rx_indication_out, 1'b0);
    $display("test levels done");
    sel(`RSM_SEL_PAT);
    tk(1'b0, 1'b0, 1'b1);
    repeat (64) tk(1'b0, 1'b0, 1'b0);
    cb(rx_indication_out, 1'b0);
    repeat (2) tk(1'b0, 1'b0, 1'b0);
    cb(rx_indication_out, 1'b1);
    cb(tx_indication_out, 1'b1);
    tk(1'b0, 1'b0, 1'b1);
    cb(rx_indication_out, 1'b0);
    cb(tx_indication_out, 1'b0);
    repeat (5) tk(1'b0, 1'b0, 1'b1);
    tk(1'b0, 1'b0, 1'b0);
    cb(rx_indication_out, 1'b1);
    tk(1'b0, 1'b0, 1'b1);
    tk(1'b0, 1'b0, 1'b0);
    cb(rx_indication_out, 1'b0);
    $display("test pattern done");
    summarize();
  end
endmodule
`default_nettype wire
